/* timer_core_cfg.svh */
`ifndef TIMER_CORE_CFG_SVH
`define TIMER_CORE_CFG_SVH

// Byte offsets on the register bus.
`define CTRL_OFFSET 8'h00
`define COUNT_OFFSET 8'h04
`define CHAN_CTRL_BASE 8'h10
`define CHAN_BUF_BASE 8'h30

// Control register field positions.
`define OVF_FLAG_BIT 0
`define OVF_EN_BIT 1
`define CLEAR_BIT 2
`define MODE_LSB 4
`define DIV_LSB 6
`define SRC_LSB 8
`define LEN_LSB 11
`define HIZ_BIT 15

// Channel control field positions.
`define CH_FLAG_BIT 0
`define CH_EN_BIT 4

// Maximum counts per length.
`define MAX_COUNT_8 16'h00ff
`define MAX_COUNT_10 16'h03ff
`define MAX_COUNT_12 16'h0fff
`define MAX_COUNT_16 16'hffff

// Reset values.
`define CTRL_RESET 16'h0000
`define COUNT_RESET 16'h0000

`endif

/* timer_core_pkg.sv */
package timer_core_pkg;

  // Operating modes in field order.
  typedef enum logic [1:0] {
    mode_stop,
    mode_up,
    mode_cont,
    mode_updown
  } mode_t;

  // Counter lengths in field order.
  typedef enum logic [1:0] {
    len_8,
    len_10,
    len_12,
    len_16
  } length_t;

  // Timer clock sources in field order.
  typedef enum logic [1:0] {
    src_aux,
    src_sub_main,
    src_external,
    src_external_inv
  } source_t;

endpackage : timer_core_pkg

/* multilength_timer_core.sv */
`timescale 1ns/100ps
`default_nettype none
`include "timer_core_cfg.svh"

// Counter core of a multi-length timer with a register bus.
// The counter runs at 8, 10, 12 or 16 bits and steps once
// per divided edge of the selected timer source.
// Modes: stop, up to the period, continuous, up/down.
// Latch zero is the period in up and up/down modes.
// In continuous mode it is an ordinary compare value.
// Counting sets flags; a count or latch write never does.
// A counting event wins over a clear in the same cycle.
// Sources are sampled as levels in the clk domain, so a
// source must run well below half the clk rate.
// Only immediate latch loading is built; deferred loads
// and latch grouping are left out to keep the core small.
// Interrupt routing and output units sit outside.
module multilength_timer_core
  import timer_core_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic aux_clock,
  input wire logic sub_main_clock,
  input wire logic external_timer_clock,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [15:0] count_value,
  output logic overflow_request,
  output logic [CHANNELS-1:0] channel_request,
  output logic [CHANNELS-1:0] channel_out,
  output logic [CHANNELS-1:0] channel_out_oe_n
);

  // The whole state of the block in one record.
  // One packed struct lets reset and the clock enable
  // act on every bit alike, with nothing left outside.
  // Nothing else in the module holds state.
  typedef struct packed {
    logic [31:0] rdata;                    // Read data held for the bus.
    logic wait_n_ack;                      // Waitrequest as seen on the bus.
    logic [15:0] count;                    // Counter value.
    logic dir_down;                        // Up/down direction, latched.
    logic halted;                          // Stopped by a zero period load.
    logic [2:0] div_cnt;                   // Clock divider state.
    logic [2:0] src_prev; // Previous levels of the three source inputs.
    mode_t mode;                           // Operating mode.
    logic [1:0] div_sel;                   // Divider selection.
    source_t src_sel;                      // Clock source selection.
    length_t len_sel;                      // Counter length selection.
    logic hiz;                             // Outputs floated when set.
    logic ovf_en;                          // Overflow request enable.
    logic ovf_flag;                        // Overflow flag.
    logic ovf_req;                         // Registered overflow request.
    logic [CHANNELS-1:0] ch_en;            // Channel request enables.
    logic [CHANNELS-1:0] ch_flag;          // Channel flags.
    logic [CHANNELS-1:0] ch_req;           // Registered channel requests.
    logic [CHANNELS-1:0] ch_eq;            // Counter equals latch.
    logic [CHANNELS-1:0][15:0] latch;      // Compare latches, zero is the period.
  } state_t;

  // The only sequential variable of the module.
  state_t st;        // Registered state.
  state_t next_st;   // Next state.

  // Maximum count for a length, shared by masking and wrap logic.
  // The register is always 16 bits; a shorter length only
  // moves the wrap point and masks the upper bits.
  function automatic logic [15:0] max_of(input length_t len);
    case (len)
      len_8: max_of = `MAX_COUNT_8;
      len_10: max_of = `MAX_COUNT_10;
      len_12: max_of = `MAX_COUNT_12;
      default: max_of = `MAX_COUNT_16;
    endcase
  endfunction : max_of

  // Merge the low two bus lanes into a 16-bit register.
  // Every register is 16 bits wide, so the upper two
  // lanes carry nothing and their enables are ignored.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                         input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  // Combinational work variables.
  // Each is written on every path of the single
  // combinational process, so none can infer a latch.
  // None of them is seen outside the module.
  logic src_edge;           // Rising edge of the selected source.
  logic tick;               // Divided count step.
  logic [2:0] div_last;     // Last divider value before a tick.
  logic [15:0] max_cnt;     // Maximum count of the active length.
  logic [15:0] period;      // Period masked to the active length.
  logic updown_as_cont;     // Period beyond the maximum in up/down mode.
  logic ovf_set;            // Overflow event from counting.
  logic [CHANNELS-1:0] ch_set;  // Channel events from counting.
  logic stepped;            // The counter moved by counting this cycle.
  logic take;               // Bus write completes this cycle.
  logic [15:0] ctrl_word;   // Control value written by the bus.
  logic [15:0] wr16;        // Merged write value.

  // All next-state logic lives here; bus writes follow counting so they override the count, but not flag events.
  // Every field starts as its current value, so it holds.
  always_comb begin
    next_st = st;
    ovf_set = 1'b0;
    ch_set = '0;
    stepped = 1'b0;
    ctrl_word = '0;
    wr16 = '0;
    max_cnt = max_of(st.len_sel);
    period = st.latch[0] & max_cnt;
    updown_as_cont = (st.latch[0] > max_cnt);

    // Pick the timer clock; the inputs are already in this clock domain.
    // Each raw input keeps its own history, so switching
    // the selection never fakes an edge from the old level.
    // History starts low, so an input idling high looks
    // like an edge after reset; the mode is stop by then.
    case (st.src_sel)
      src_aux: begin
        src_edge = aux_clock & ~st.src_prev[0];
      end
      src_sub_main: begin
        src_edge = sub_main_clock & ~st.src_prev[1];
      end
      src_external: begin
        src_edge = external_timer_clock & ~st.src_prev[2];
      end
      default: begin
        // The inverted input rises where the raw one falls.
        src_edge = ~external_timer_clock & st.src_prev[2];
      end
    endcase
    next_st.src_prev = {external_timer_clock, sub_main_clock, aux_clock};

    // The divider counts source edges only while the timer runs, so stop freezes it.
    // div_last is the value at which the next edge steps:
    // 0, 1, 3 or 7 for division by 1, 2, 4 or 8.
    div_last = 3'((4'h1 << st.div_sel) - 4'h1);
    tick = 1'b0;
    if (st.mode != mode_stop && src_edge && !st.halted) begin
      if (st.div_cnt >= div_last) begin
        next_st.div_cnt = '0;
        tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
      end
    end

    // One count step per divided edge, by mode.
    // stepped marks a real counting move; compares and
    // flags listen to it and never to a bus write.
    if (tick) begin
      stepped = 1'b1;
      case (st.mode)
        mode_up: begin
          // A zero period parks the counter where it is.
          // At or past the period the count goes to zero.
          // Only the step from exactly the period is an
          // overflow, so a shortened period rolls quietly.
          if (period == '0) begin
            stepped = 1'b0;
          end else if (st.count >= period) begin
            next_st.count = '0;
            ovf_set = (st.count == period);
          end else begin
            next_st.count = st.count + 16'h1;
          end
        end
        mode_updown: begin
          // The direction survives stop and restart; only a
          // clear or a restart after a zero period resets it.
          if (updown_as_cont) begin
            // A period past the maximum behaves as continuous mode.
            next_st.count = (st.count >= max_cnt) ? '0 : st.count + 16'h1;
            ovf_set = (st.count == max_cnt);
          end else if (period == '0) begin
            stepped = 1'b0;
          end else if (st.dir_down) begin
            // Descending: a new period only takes effect at the bottom.
            if (st.count <= 16'h1) begin
              next_st.count = '0;
              next_st.dir_down = 1'b0;
              ovf_set = (st.count == 16'h1);
            end else begin
              next_st.count = st.count - 16'h1;
            end
          end else if (st.count >= period) begin
            // At or above the period: turn round and step down at once, with no extra count.
            next_st.dir_down = 1'b1;
            next_st.count = st.count - 16'h1;
          end else begin
            next_st.count = st.count + 16'h1;
          end
        end
        mode_cont: begin
          // The period is ignored; the wrap is at the maximum
          // and channel zero compares like the others.
          next_st.count = (st.count >= max_cnt) ? '0 : st.count + 16'h1;
          ovf_set = (st.count == max_cnt);
        end
        default: begin
          // Stop never gets here, since tick needs a mode.
          stepped = 1'b0;
        end
      endcase
    end

    // Compare events fire only on a counting step, never on a bus write.
    // The compare looks at the value being moved to, so a
    // flag rises in the cycle count_value shows the match.
    // Latches are masked to the length, as the count is.
    for (int i = 0; i < CHANNELS; i++) begin
      if (stepped && next_st.count == (st.latch[i] & max_cnt)) begin
        ch_set[i] = 1'b1;
      end
    end

    // Clear: counter, divider and direction all return to zero.
    // The clear bit is a command and never stored, so it reads back as zero.
    // It is applied with the control write below, after
    // counting, so a clear beats a step in the same cycle.

    // Bus slave: one wait cycle, then the access completes.
    // The first cycle of a request registers read data
    // and drops waitrequest; the second completes it.
    // A master that holds its request as the bus demands
    // thus sees exactly one wait state.
    // Unmapped reads return zero; unmapped writes vanish.
    take = 1'b0;
    if ((read || write) && st.wait_n_ack) begin
      next_st.wait_n_ack = 1'b0;
      next_st.rdata = '0;
      if (read) begin
        if (address == `CTRL_OFFSET) begin
          next_st.rdata[`OVF_FLAG_BIT] = st.ovf_flag;
          next_st.rdata[`OVF_EN_BIT] = st.ovf_en;
          next_st.rdata[`MODE_LSB +: 2] = st.mode;
          next_st.rdata[`DIV_LSB +: 2] = st.div_sel;
          next_st.rdata[`SRC_LSB +: 2] = st.src_sel;
          next_st.rdata[`LEN_LSB +: 2] = st.len_sel;
          next_st.rdata[`HIZ_BIT] = st.hiz;
        end else if (address == `COUNT_OFFSET) begin
          next_st.rdata[15:0] = st.count;
          // Sources are synchronous here, so the read is
          // coherent even while the timer runs.
        end
        for (int i = 0; i < CHANNELS; i++) begin
          if (address == 8'(`CHAN_CTRL_BASE + 4 * i)) begin
            // No synchronized capture status bit exists here.
            next_st.rdata[`CH_FLAG_BIT] = st.ch_flag[i];
            next_st.rdata[`CH_EN_BIT] = st.ch_en[i];
          end
          if (address == 8'(`CHAN_BUF_BASE + 4 * i)) begin
            next_st.rdata[15:0] = st.latch[i];
          end
        end
      end
    end else if ((read || write) && !st.wait_n_ack) begin
      next_st.wait_n_ack = 1'b1;
      take = write;
    end

    // Writes land at the edge where waitrequest is seen low.
    // They follow the counting logic on purpose: a count
    // write beats a step in that cycle and lands at once.
    // Setup should only change while stopped; the core
    // does not guard against a change while it runs.
    if (take) begin
      if (address == `CTRL_OFFSET) begin
        ctrl_word = merge16({st.hiz, 2'b00, st.len_sel, 1'b0, st.src_sel, st.div_sel,
                             st.mode, 1'b0, 1'b0, st.ovf_en, st.ovf_flag},
                            writedata, byteenable);
        next_st.ovf_flag = ctrl_word[`OVF_FLAG_BIT];
        next_st.ovf_en = ctrl_word[`OVF_EN_BIT];
        next_st.mode = mode_t'(ctrl_word[`MODE_LSB +: 2]);
        next_st.div_sel = ctrl_word[`DIV_LSB +: 2];
        next_st.src_sel = source_t'(ctrl_word[`SRC_LSB +: 2]);
        next_st.len_sel = length_t'(ctrl_word[`LEN_LSB +: 2]);
        next_st.hiz = ctrl_word[`HIZ_BIT];
        if (ctrl_word[`CLEAR_BIT]) begin
          next_st.count = '0;
          next_st.div_cnt = '0;
          next_st.dir_down = 1'b0;
        end
      end else if (address == `COUNT_OFFSET) begin
        // Right-aligned, upper bits forced to zero at short lengths.
        next_st.count = merge16(st.count, writedata, byteenable) & max_cnt;
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (address == 8'(`CHAN_CTRL_BASE + 4 * i)) begin
          wr16 = merge16({11'h000, st.ch_en[i], 3'h0, st.ch_flag[i]}, writedata,
                         byteenable);
          next_st.ch_flag[i] = wr16[`CH_FLAG_BIT];
          next_st.ch_en[i] = wr16[`CH_EN_BIT];
        end
        if (address == 8'(`CHAN_BUF_BASE + 4 * i)) begin
          // Immediate load: the buffer goes straight to the latch.
          // A zero period in up or up/down halts counting;
          // the next nonzero one restarts up from zero.
          wr16 = merge16(st.latch[i], writedata, byteenable);
          next_st.latch[i] = wr16;
          if (i == 0 && (st.mode == mode_up || st.mode == mode_updown)) begin
            if (wr16 == '0) begin
              next_st.halted = 1'b1;
            end else if (st.halted) begin
              next_st.halted = 1'b0;
              next_st.count = '0;
              next_st.dir_down = 1'b0;
            end
          end
        end
      end
    end

    // A counting event wins over a clear in the same cycle.
    // Software clears a flag by writing zero; an event in
    // that same cycle must not be lost.
    next_st.ovf_flag = next_st.ovf_flag | ovf_set;
    next_st.ch_flag = next_st.ch_flag | ch_set;

    // Requests and equality outputs are registered copies.
    // They come from the next state, so a request shows
    // in the same cycle as its flag, with no extra lag.
    next_st.ovf_req = next_st.ovf_flag & next_st.ovf_en;
    next_st.ch_req = next_st.ch_flag & next_st.ch_en;
    // channel_out is bare equality, not sticky: it tracks the count.
    for (int i = 0; i < CHANNELS; i++) begin
      next_st.ch_eq[i] = (next_st.count == (next_st.latch[i] & max_of(next_st.len_sel)));
    end
  end

  // State register; the clock enable freezes everything, the bus included.
  // Reset loads constants only: all zero but waitrequest,
  // which idles high so no access completes in reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.wait_n_ack <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  // No output passes through logic after its flip-flop.
  // One shared bit floats all channel outputs together.
  assign readdata = st.rdata;
  assign waitrequest = st.wait_n_ack;
  assign count_value = st.count;
  assign overflow_request = st.ovf_req;
  assign channel_request = st.ch_req;
  assign channel_out = st.ch_eq;
  assign channel_out_oe_n = {CHANNELS{st.hiz}};

endmodule : multilength_timer_core
`default_nettype wire

/* timer_core_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the timer core from its ports only; bound in from the testbench.
module timer_core_monitor #(
  parameter int CHANNELS = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [15:0] count_value,
  input wire logic overflow_request,
  input wire logic [CHANNELS-1:0] channel_request,
  input wire logic [CHANNELS-1:0] channel_out_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // A taken request is answered on the very next edge.
  a_bus_answer_next: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  // The answer lasts one cycle, so the master never sees a second completion.
  a_wait_one_cycle: assert property (!waitrequest && ce |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_bus_idle_wait: assert property (!read && !write && !$past(read) && !$past(write) |-> waitrequest)
    else $error("waitrequest low with no request");
  a_read_upper_zero: assert property (!waitrequest && read |-> readdata[31:16] == 16'h0000)
    else $error("upper read lanes not zero");
  // Outside software writes the count only moves by one step or a roll to zero.
  a_count_one_step: assert property (!$past(write) && $changed(count_value) |->
    count_value == $past(count_value) + 16'h0001 || count_value == $past(count_value) - 16'h0001
    || count_value == 16'h0000)
    else $error("count jumped without a write");
  // An overflow raised by counting always coincides with a step onto zero.
  a_ovf_on_zero: assert property ($rose(overflow_request) && !$past(write) |->
    count_value == 16'h0000 && $changed(count_value))
    else $error("overflow request without a step to zero");
  a_chan_on_step: assert property ($rose(channel_request[0]) && !$past(write) |->
    $changed(count_value))
    else $error("channel request without a counting step");
  // The float control is one shared bit, changed only by software.
  a_float_uniform: assert property ((channel_out_oe_n == '0 || channel_out_oe_n == '1) and
    ($changed(channel_out_oe_n) |-> $past(write)))
    else $error("output float enables inconsistent");
  c_overflow: cover property ($rose(overflow_request));
  c_period: cover property ($rose(channel_request[0]));
  c_read: cover property (read && !waitrequest);
endmodule : timer_core_monitor
`default_nettype wire

/* multilength_timer_core_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module multilength_timer_core_tb;
  import timer_core_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic aux_clock = 1'b1;
  logic sub_main_clock = 1'b1;
  logic ext_clk = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] count_value;
  logic overflow_request;
  logic [2:0] channel_request;
  logic [2:0] channel_out;
  logic [2:0] channel_out_oe_n;
  logic [15:0] rd;
  logic [15:0] r;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int i;
  int p;
  int ud [6] = '{1, 2, 3, 2, 1, 0};
  // Core under test; ce and byte lanes stay enabled throughout.
  multilength_timer_core #(.CHANNELS(3)) dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .aux_clock(aux_clock), .sub_main_clock(sub_main_clock), .external_timer_clock(ext_clk),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .count_value(count_value), .overflow_request(overflow_request),
    .channel_request(channel_request), .channel_out(channel_out),
    .channel_out_oe_n(channel_out_oe_n));
  always #2 clk = ~clk;
  // Cuts a hang short; the whole run needs far fewer cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus transfer; held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[15:0];
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clk);
  endtask : bus
  // One rising edge of source s; source 3 is the inverted external clock.
  task automatic tk(input int s);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      case (s)
        0: aux_clock <= k[0];
        1: sub_main_clock <= k[0];
        default: ext_clk <= k[0] ^ (s == 3);
      endcase
    end
    repeat (3) @(posedge clk);
  endtask : tk
  function automatic logic [15:0] cw(input mode_t m, input source_t s, input length_t l,
                                     input logic [1:0] d, input logic clr);
    cw = {3'b000, l, 1'b0, s, d, m, 1'b0, clr, 2'b10};
  endfunction : cw
  function automatic logic [15:0] maxc(input int l);
    maxc = (l == 0) ? 16'h00ff : (l == 1) ? 16'h03ff : (l == 2) ? 16'h0fff : 16'hffff;
  endfunction : maxc
  initial begin
    void'($urandom(32'h8b550285));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 8'h00, 16'h0000);
    chk("ctrl reset", 16'h0000, rd);
    chk("count reset", 16'h0000, count_value);
    chk("ovf reset", 16'h0000, {15'h0, overflow_request});
    $display("Test reset done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, cw(mode_stop, src_aux, length_t'(i), 2'd0, 1'b0));
      r = 16'($urandom) | 16'hf800;
      bus(1'b1, 8'h04, r);
      bus(1'b0, 8'h04, 16'h0000);
      chk("masked count", r & maxc(i), rd);
    end
    $display("Test lengths done");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, cw(mode_cont, source_t'(i), len_16, 2'd0, 1'b0));
      r = 16'($urandom_range(16'hfff0));
      bus(1'b1, 8'h04, r);
      tk(i);
      chk("source step", r + 16'h0001, count_value);
      tk(i ^ 1);
      chk("other source", r + 16'h0001, count_value);
    end
    for (i = 1; i < 4; i++) begin
      bus(1'b1, 8'h00, cw(mode_cont, src_aux, len_16, 2'(i), 1'b1));
      chk("clear", 16'h0000, count_value);
      repeat ((1 << i) - 1) tk(0);
      chk("divider hold", 16'h0000, count_value);
      tk(0);
      chk("divider step", 16'h0001, count_value);
    end
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b0));
    tk(0);
    chk("stopped", 16'h0001, count_value);
    $display("Test clocking done");
    bus(1'b1, 8'h00, cw(mode_cont, src_aux, len_8, 2'd0, 1'b0));
    bus(1'b1, 8'h34, 16'h0001);
    bus(1'b1, 8'h14, 16'h0010);
    bus(1'b1, 8'h04, 16'h00ff);
    chk("written max", 16'h0000, {15'h0, overflow_request});
    tk(0);
    chk("wrap", 16'h0000, count_value);
    chk("ovf at wrap", 16'h0001, {15'h0, overflow_request});
    chk("chan0 compare", 16'h0001, {15'h0, channel_out[0]});
    tk(0);
    chk("chan1 request", 16'h0001, {15'h0, channel_request[1]});
    chk("chan1 equal", 16'h0001, {15'h0, channel_out[1]});
    $display("Test continuous done");
    p = $urandom_range(5, 2);
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b1));
    bus(1'b1, 8'h30, 16'(p));
    bus(1'b1, 8'h10, 16'h0010);
    bus(1'b1, 8'h00, cw(mode_up, src_aux, len_16, 2'd0, 1'b0));
    for (i = 1; i <= p; i++) begin
      tk(0);
      chk("up count", 16'(i), count_value);
      chk("up ovf early", 16'h0000, {15'h0, overflow_request});
    end
    chk("period flag", 16'h0001, {15'h0, channel_request[0]});
    tk(0);
    chk("up wrap", 16'h0000, count_value);
    chk("up ovf", 16'h0001, {15'h0, overflow_request});
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b0));
    bus(1'b1, 8'h04, 16'h0009);
    bus(1'b1, 8'h00, cw(mode_up, src_aux, len_16, 2'd0, 1'b0));
    tk(0);
    chk("above period", 16'h0000, count_value);
    repeat (2) tk(0);
    bus(1'b1, 8'h30, 16'h0000);
    tk(0);
    chk("halted", 16'h0002, count_value);
    bus(1'b1, 8'h30, 16'h0003);
    tk(0);
    chk("restart", 16'h0001, count_value);
    bus(1'b1, 8'h30, 16'h0006);
    repeat (5) tk(0);
    chk("longer period", 16'h0006, count_value);
    repeat (5) tk(0);
    bus(1'b1, 8'h30, 16'h0002);
    tk(0);
    if (count_value === 16'h0005) begin
      tk(0);
    end
    chk("shorter period", 16'h0000, count_value);
    $display("Test up mode done");
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b1));
    bus(1'b1, 8'h30, 16'h0003);
    bus(1'b1, 8'h10, 16'h0010);
    bus(1'b1, 8'h00, cw(mode_updown, src_aux, len_16, 2'd0, 1'b0));
    for (i = 0; i < 10; i++) begin
      tk(0);
      chk("updown count", 16'(ud[i % 6]), count_value);
      if (i < 6) begin
        chk("updown ovf", 16'(i == 5), {15'h0, overflow_request});
        chk("updown chan0", 16'(i >= 2), {15'h0, channel_request[0]});
      end
    end
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b0));
    bus(1'b1, 8'h00, cw(mode_updown, src_aux, len_16, 2'd0, 1'b0));
    tk(0);
    chk("direction held", 16'h0001, count_value);
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b1));
    bus(1'b1, 8'h04, 16'h0002);
    bus(1'b1, 8'h00, cw(mode_updown, src_aux, len_16, 2'd0, 1'b0));
    tk(0);
    chk("direction cleared", 16'h0003, count_value);
    $display("Test updown done");
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b0) | 16'h8000);
    tk(0);
    chk("outputs float", 16'h0007, {13'h0, channel_out_oe_n});
    bus(1'b1, 8'h00, cw(mode_stop, src_aux, len_16, 2'd0, 1'b0));
    tk(0);
    chk("outputs driven", 16'h0000, {13'h0, channel_out_oe_n});
    bus(1'b0, 8'h80, 16'h0000);
    chk("unmapped read", 16'h0000, rd);
    $display("Test outputs done");
    results();
  end
endmodule : multilength_timer_core_tb
bind multilength_timer_core timer_core_monitor #(.CHANNELS(CHANNELS)) mon (.clk(clk),
  .nrst(nrst), .ce(ce), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .count_value(count_value), .overflow_request(overflow_request),
  .channel_request(channel_request), .channel_out_oe_n(channel_out_oe_n));
`default_nettype wire
